/* bus_model.sv */
`timescale 1ns/1ps
module bus_model
  import mac_pkg::*;
(
  // clock and request
  input  wire logic              core_clk,
  input  wire logic              busValid,
  input  wire logic [DATA_W-1:0] dataWord,
  input  wire logic [DATA_W-1:0] progWord,
  // bus lines
  output logic      [DATA_W-1:0] dataBus,
  output logic      [DATA_W-1:0] progBus
);
  logic [DATA_W-1:0] lastData = '0; // last data word
  logic [DATA_W-1:0] lastProg = '0; // last program word
  // remember what was driven
  always_ff @(posedge core_clk) begin
    if (busValid) begin
      lastData <= dataWord;
      lastProg <= progWord;
    end
  end
  // both buses in one cycle, released bus shows inverse
  assign dataBus = busValid ? dataWord : ~lastData;
  assign progBus = busValid ? progWord : ~lastProg;
endmodule

/* dsp_multiply_accumulate_datapath_bench.sv */
`timescale 1ns/1ps
module dsp_multiply_accumulate_datapath_bench;
  import mac_pkg::*;
  logic        core_clk, reset_n, busValid; // clock, reset, bus drive
  mac_cmd_t    cmd, c;                      // command
  logic [15:0] dataWord, progWord, dataBus, progBus, sh, sl, bt, opr;
  logic [31:0] acc, pr;                     // results
  mac_status_t status;                      // flags
  int          failures, checks, cycles;    // counters
  bus_model i_bus_model (.core_clk(core_clk), .busValid(busValid), .dataWord(dataWord),
    .progWord(progWord), .dataBus(dataBus), .progBus(progBus));
  mac_datapath i_mac_datapath (.core_clk(core_clk), .reset_n(reset_n), .cmd(cmd),
    .dataBus(dataBus), .progBus(progBus), .accumulator(acc), .multiplier_result_reg(pr),
    .multiplier_operand_reg(opr), .storeHigh(sh), .storeLow(sl), .branchTarget(bt),
    .status(status));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task stop_test;
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function mac_cmd_t mk(alu_op_t o, logic [4:0] s);
    mk = '0;
    mk.op = o;
    mk.shiftCount = s;
  endfunction
  // one command at a rising edge
  task step(input mac_cmd_t k, input logic [15:0] d, input logic [15:0] p);
    @(posedge core_clk);
    cmd <= k;
    dataWord <= d;
    progWord <= p;
    busValid <= 1'h1;
  endtask
  // idle edge, then results settle
  task done;
    @(posedge core_clk);
    cmd <= '0;
    busValid <= 1'h0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_scaler;
    logic [31:0] e;
    for (int x = 0; x < 2; x++) begin
      for (int s = 0; s <= 16; s += 4) begin
        e = (x ? 32'hFFFF8001 : 32'h00008001) << s;
        c = mk(OP_LOAD, 5'(s));
        c.signExtend = x[0];
        step(c, 16'h8001, 16'h0);
        done;
        chk("scaled", acc, e);
      end
    end
  endtask
  task t_mul;
    step(mk(OP_LDOP, 0), 16'h8000, 16'h0);
    c = mk(OP_MPY, 0);
    step(c, 16'h0003, 16'h0);
    done;
    chk("unsigned", pr, 32'h00018000);
    chk("operand", opr, 16'h8000);
    c.mulSigned = 1'h1;
    step(c, 16'h0003, 16'h0);
    done;
    done;
    chk("signed", pr, 32'hFFFE8000);
  endtask
  task t_pmode;
    logic [31:0] e [4];
    e = '{32'hFFFE8000, 32'hFFFD0000, 32'hFFE80000, 32'hFFFFFA00};
    for (int m = 0; m < 4; m++) begin
      c = mk(OP_LOAD, 0);
      c.useProduct = 1'h1;
      c.pmode = pmode_t'(m);
      step(c, 16'h0, 16'h0);
      done;
      chk("pshift", acc, e[m]);
    end
    step(mk(OP_ADD, 0), 16'h0600, 16'h0);
    done;
    chk("add", acc, 32'h0);
    chk("zero", status.accZero, 1'h1);
  endtask
  task t_mac;
    c = mk(OP_MAC, 0);
    step(c, 16'h0, 16'h0002);
    c.mulSigned = 1'h1;
    step(c, 16'h0, 16'h0003);
    done;
    chk("macacc", acc, 32'hFFFF8000);
    chk("macprod", pr, 32'hFFFE8000);
  endtask
  task t_store;
    step(mk(OP_LOAD, 16), 16'h1234, 16'h0);
    step(mk(OP_ADD, 0), 16'h5678, 16'h0);
    c = mk(OP_NOP, 0);
    c.storeShift = 3'h3;
    step(c, 16'h0, 16'h0);
    done;
    chk("keep", acc, 32'h12345678);
    chk("halves", {sh, sl}, 32'h91A2B3C0);
    chk("branch", bt, 16'h5678);
  endtask
  task t_norm;
    int n;
    n = 0;
    step(mk(OP_LOAD, 12), 16'h0001, 16'h0);
    done;
    while (status.normalized !== 1'h1 && n < 40) begin
      step(mk(OP_NORM, 0), 16'h0, 16'h0);
      done;
      n++;
    end
    chk("norm", acc, 32'h40000000);
    chk("steps", n, 32'h12);
  endtask
  task t_bit;
    c = mk(OP_NOP, 0);
    c.bitSel = 4'h4;
    step(c, 16'h0010, 16'h0);
    done;
    chk("bitset", status.bitTest, 1'h1);
    c.bitSel = 4'h5;
    step(c, 16'h0010, 16'h0);
    done;
    chk("bitclr", status.bitTest, 1'h0);
  endtask
  task t_logic;
    step(mk(OP_LOAD, 0), 16'h00F0, 16'h0);
    step(mk(OP_AND, 0), 16'h0FF0, 16'h0);
    step(mk(OP_OR, 0), 16'h0F00, 16'h0);
    step(mk(OP_XOR, 0), 16'h00FF, 16'h0);
    done;
    chk("logic", acc, 32'h00000F0F);
    step(mk(OP_NEG, 0), 16'h0, 16'h0);
    done;
    chk("neg", acc, 32'hFFFFF0F1);
    chk("negflag", status.accNeg, 1'h1);
    step(mk(OP_ABS, 0), 16'h0, 16'h0);
    done;
    chk("abs", acc, 32'h00000F0F);
    step(mk(OP_SUB, 0), 16'h0F10, 16'h0);
    done;
    chk("sub", acc, 32'hFFFFFFFF);
    chk("borrow", status.carry, 1'h0);
    step(mk(OP_LOAD, 16), 16'h8000, 16'h0);
    step(mk(OP_SUB, 0), 16'h0001, 16'h0);
    done;
    chk("subovf", acc, 32'h7FFFFFFF);
    chk("ovf", status.overflow, 1'h1);
    chk("noborrow", status.carry, 1'h1);
  endtask
  task t_reset;
    @(posedge core_clk);
    reset_n <= 1'h0;
    cmd <= '0;
    busValid <= 1'h0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("rstprod", pr, 32'h0);
    chk("rstopr", opr, 16'h0);
    chk("rsthalves", {sh, sl}, 32'h0);
    chk("rstbranch", bt, 16'h0);
    chk("rstnorm", status.normalized, 1'h1);
    @(posedge core_clk);
    reset_n <= 1'h1;
    step(mk(OP_LOAD, 4), 16'h0003, 16'h0);
    done;
    chk("afterrst", acc, 32'h00000030);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // free running clock
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      stop_test;
    end
  end
  // main sequence
  initial begin
    reset_n = 1'h0;
    busValid = 1'h0;
    cmd = '0;
    dataWord = 16'h0;
    progWord = 16'h0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'h1;
    #1;
    chk("reset", acc, 32'h0);
    t_scaler;
    t_mul;
    t_pmode;
    t_mac;
    t_store;
    t_norm;
    t_bit;
    t_logic;
    t_reset;
    stop_test;
  end
endmodule

/* mac_datapath.sv */
`timescale 1ns/1ps
module mac_datapath
  import mac_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // decoder command
  input  wire mac_cmd_t          cmd,
  // buses
  input  wire logic [DATA_W-1:0] dataBus,
  input  wire logic [DATA_W-1:0] progBus,
  // results
  output logic      [ACC_W-1:0]  accumulator,
  output logic      [ACC_W-1:0]  multiplier_result_reg,
  output logic      [DATA_W-1:0] multiplier_operand_reg,
  output logic      [DATA_W-1:0] storeHigh,
  output logic      [DATA_W-1:0] storeLow,
  output logic      [DATA_W-1:0] branchTarget,
  output mac_status_t            status
);

  ////////////////////////////////////////////////////////////////////////////
  // internal nets
  logic [ACC_W-1:0]   scaled;        // scaler output
  logic [ACC_W-1:0]   prodShifted;   // product after mode shift
  logic [ACC_W-1:0]   operandB;      // second alu input
  logic [ACC_W:0]     sumWide;       // add/sub with carry
  logic [ACC_W-1:0]   next_acc;      // alu result
  logic               next_carry;    // carry result
  logic               next_ovf;      // overflow result
  logic [ACC_W-1:0]   newProduct;    // multiplier output
  logic [DATA_W-1:0]  mulB;          // second multiplier input
  logic               isMulOp;       // product updates this cycle
  logic [ACC_W-1:0]   storeWord;     // shifted accumulator copy
  logic               carryFlag;     // registered carry
  logic               ovfFlag;       // registered overflow
  logic               bitFlag;       // registered bit test

  ////////////////////////////////////////////////////////////////////////////
  // input scaling shifter
  scaling_shifter uScale (
    .dataIn     (dataBus),
    .shiftCount (cmd.shiftCount),
    .signExtend (cmd.signExtend),
    .dataOut    (scaled)
  );

  // product shift path
  product_shifter uPshift (
    .product (multiplier_result_reg),
    .pmode   (cmd.pmode),
    .shifted (prodShifted)
  );

  ////////////////////////////////////////////////////////////////////////////
  // operand b select
  always_comb begin
    operandB = cmd.useProduct ? prodShifted : scaled;
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiplier, mac takes program bus with operand register
  always_comb begin
    isMulOp = (cmd.op == OP_MPY) || (cmd.op == OP_MAC);
    // mac: operand from program bus, other from operand register
    mulB = (cmd.op == OP_MAC) ? progBus : dataBus;
    if (cmd.mulSigned) begin
      newProduct = ACC_W'($signed(multiplier_operand_reg) * $signed(mulB));
    end else begin
      newProduct = ACC_W'(multiplier_operand_reg * mulB);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alu, one result per cycle
  always_comb begin
    next_acc   = accumulator;
    next_carry = carryFlag;
    next_ovf   = 1'b0;
    sumWide    = '0;
    case (cmd.op)
      OP_ADD, OP_MAC: begin
        // mac adds the shifted previous product
        sumWide    = {1'b0, accumulator} + {1'b0, (cmd.op == OP_MAC) ? prodShifted : operandB};
        next_acc   = sumWide[ACC_W-1:0];
        next_carry = sumWide[ACC_W];
        next_ovf   = (accumulator[ACC_W-1] == sumWide[ACC_W-1] ? 1'b0 : 1'b1)
                   & ~(accumulator[ACC_W-1] ^ ((cmd.op == OP_MAC) ?
                       prodShifted[ACC_W-1] : operandB[ACC_W-1]));
      end
      OP_SUB: begin
        sumWide    = {1'b0, accumulator} - {1'b0, operandB};
        next_acc   = sumWide[ACC_W-1:0];
        next_carry = ~sumWide[ACC_W];
        next_ovf   = (accumulator[ACC_W-1] ^ operandB[ACC_W-1])
                   & (accumulator[ACC_W-1] ^ sumWide[ACC_W-1]);
      end
      OP_LOAD: next_acc = operandB;
      OP_AND:  next_acc = accumulator & operandB;
      OP_OR:   next_acc = accumulator | operandB;
      OP_XOR:  next_acc = accumulator ^ operandB;
      OP_ABS:  next_acc = accumulator[ACC_W-1] ? ACC_W'(-accumulator) : accumulator;
      OP_NEG:  next_acc = ACC_W'(-accumulator);
      OP_NORM: begin
        // shift left once while top two bits agree and accumulator is nonzero
        if (accumulator[ACC_W-1] == accumulator[ACC_W-2] && accumulator != ACC_RESET) begin
          next_acc = accumulator << 1;
        end
      end
      default: next_acc = accumulator;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator write back
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      accumulator <= ACC_RESET;
    end else begin
      accumulator <= next_acc;
    end
  end

  // flags from the alu
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      carryFlag <= 1'b0;
      ovfFlag   <= 1'b0;
    end else begin
      carryFlag <= next_carry;
      ovfFlag   <= next_ovf;
    end
  end

  // operand register, loaded from data bus
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      multiplier_operand_reg <= OPR_RESET;
    end else if (cmd.op == OP_LDOP) begin
      multiplier_operand_reg <= dataBus;
    end
  end

  // product register, held between multiplies
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      multiplier_result_reg <= ACC_RESET;
    end else if (isMulOp) begin
      multiplier_result_reg <= newProduct;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // store path: shifted copy, accumulator untouched
  always_comb begin
    storeWord = accumulator << cmd.storeShift;
  end

  // registered store halves
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      storeHigh <= OPR_RESET;
      storeLow  <= OPR_RESET;
    end else begin
      storeHigh <= storeWord[ACC_W-1:DATA_W];
      storeLow  <= storeWord[DATA_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // branch target and bit test
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      branchTarget <= OPR_RESET;
      bitFlag      <= 1'b0;
    end else begin
      branchTarget <= next_acc[DATA_W-1:0];
      bitFlag      <= dataBus[cmd.bitSel];
    end
  end

  // status word, one driver for the whole struct
  always_comb begin
    status.carry      = carryFlag;
    status.overflow   = ovfFlag;
    status.bitTest    = bitFlag;
    status.accZero    = (accumulator == ACC_RESET);
    status.accNeg     = accumulator[ACC_W-1];
    status.normalized = (accumulator[ACC_W-1] != accumulator[ACC_W-2]) ||
                        (accumulator == ACC_RESET);
  end

endmodule

/* mac_datapath_props.sv */
`timescale 1ns/1ps
module mac_datapath_props
  import mac_pkg::*;
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              reset_n,
  // decoder and buses
  input wire mac_cmd_t          cmd,
  input wire logic [DATA_W-1:0] dataBus,
  input wire logic [DATA_W-1:0] progBus,
  // results
  input wire logic [ACC_W-1:0]  accumulator,
  input wire logic [ACC_W-1:0]  multiplier_result_reg,
  input wire logic [DATA_W-1:0] multiplier_operand_reg,
  input wire logic [DATA_W-1:0] storeHigh,
  input wire logic [DATA_W-1:0] storeLow,
  input wire logic [DATA_W-1:0] branchTarget,
  input wire mac_status_t       status
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  // short aliases
  logic [ACC_W-1:0]  acc; // accumulator
  logic [ACC_W-1:0]  pr;  // product
  logic [DATA_W-1:0] opr; // operand
  alu_op_t           op;  // current op
  assign acc = accumulator;
  assign pr = multiplier_result_reg;
  assign opr = multiplier_operand_reg;
  assign op = cmd.op;
  ////////////////////////////////////////////////////////////////////////////
  operand_load_a:
    assert property (op == OP_LDOP |=> opr == $past(dataBus)) else $error("operand load");
  product_hold_a:
    assert property (!(op inside {OP_MPY, OP_MAC}) |=> $stable(pr)) else $error("product moved");
  signed_mpy_a:
    assert property (op == OP_MPY && cmd.mulSigned |=> pr == 32'($signed($past(opr))
      * $signed($past(dataBus)))) else $error("signed product");
  mac_prog_a:
    assert property (op == OP_MAC && !cmd.mulSigned |=> pr == {16'h0, $past(opr)}
      * {16'h0, $past(progBus)}) else $error("mac product");
  mac_acc_a:
    assert property (op == OP_MAC && cmd.pmode == PM_NONE |=> acc == $past(acc) + $past(pr))
      else $error("mac accumulate");
  right_six_a:
    assert property (op == OP_LOAD && cmd.useProduct && cmd.pmode == PM_R6
      |=> acc == 32'($signed($past(pr)) >>> 6)) else $error("right shift six");
  store_halves_a:
    assert property (##1 {storeHigh, storeLow} == $past(acc) << $past(cmd.storeShift))
      else $error("store halves");
  nop_hold_a:
    assert property (op == OP_NOP |=> $stable(acc)) else $error("accumulator moved");
  branch_acc_a:
    assert property (branchTarget == acc[15:0]) else $error("branch target");
  norm_flag_a:
    assert property (status.normalized == (acc == 0 || acc[31] != acc[30]))
      else $error("normalized flag");
  // main scenarios
  mac_seen_c: cover property (op == OP_MAC ##1 op == OP_MAC);
  norm_seen_c: cover property (op == OP_NORM ##1 status.normalized);
  store_seen_c: cover property (cmd.storeShift == 3'h3);
endmodule
bind mac_datapath mac_datapath_props i_mac_datapath_props (
  .core_clk(core_clk), .reset_n(reset_n), .cmd(cmd), .dataBus(dataBus),
  .progBus(progBus), .accumulator(accumulator),
  .multiplier_result_reg(multiplier_result_reg),
  .multiplier_operand_reg(multiplier_operand_reg), .storeHigh(storeHigh),
  .storeLow(storeLow), .branchTarget(branchTarget), .status(status));

/* mac_pkg.sv */
// Contract
// - 32-bit ALU with accumulator, single cycle
// - branch target taken from accumulator
// - normalize accumulator removing redundant sign bits
// - test selected data bit as condition
// - operand B from product or scaler
// - ALU result written back to accumulator
// - accumulator stored as two 16-bit halves
// - store shifters leave accumulator unchanged
// - scaler takes 16 bits, gives 32
// - scaler shifts left 0 to 16
// - scaler low vacated bits are zero
// - scaler high bits follow sign mode
// - signed/unsigned 16x16 product in one cycle
// - operand register holds one multiplier input
// - result register holds product until next
// - MAC takes both buses same cycle; here MAC multiplies program bus by operand register, data bus unused
// - product passes four-mode shifter to ALU
package mac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int DATA_W   = 16;                 // bus word
  localparam int ACC_W    = 32;                 // accumulator and product
  localparam int SHIFT_W  = 5;                  // scaler shift count field
  localparam int MAX_SHIFT = 16;                // largest scaler shift
  localparam int STORE_SHIFT_W = 3;             // store shift count field
  localparam int BITSEL_W = 4;                  // bit test selector

  // product shift amounts
  localparam int PSHIFT_L1 = 1;
  localparam int PSHIFT_L4 = 4;
  localparam int PSHIFT_R6 = 6;

  // reset values
  localparam logic [ACC_W-1:0]  ACC_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] OPR_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // alu operations
  typedef enum logic [3:0] {
    OP_NOP  = 4'b0000,  // hold accumulator
    OP_ADD  = 4'b0001,  // acc + b
    OP_SUB  = 4'b0010,  // acc - b
    OP_LOAD = 4'b0011,  // acc = b
    OP_AND  = 4'b0100,  // bitwise and
    OP_OR   = 4'b0101,  // bitwise or
    OP_XOR  = 4'b0110,  // bitwise xor
    OP_NORM = 4'b0111,  // one normalize step
    OP_MPY  = 4'b1000,  // product only
    OP_MAC  = 4'b1001,  // acc += shifted old product, new product
    OP_LDOP = 4'b1010,  // load operand register
    OP_ABS  = 4'b1011,  // absolute value
    OP_NEG  = 4'b1100   // negate
  } alu_op_t;

  // product shift modes
  typedef enum logic [1:0] {
    PM_NONE = 2'b00,
    PM_L1   = 2'b01,
    PM_L4   = 2'b10,
    PM_R6   = 2'b11
  } pmode_t;

  // command from the decoder
  typedef struct packed {
    alu_op_t                op;          // operation
    logic                   useProduct;  // operand b from product path
    logic [SHIFT_W-1:0]     shiftCount;  // scaler shift
    logic                   signExtend;  // sign_extend_mode_bit
    logic                   mulSigned;   // signed multiply
    pmode_t                 pmode;       // product shift mode
    logic [BITSEL_W-1:0]    bitSel;      // bit test index
    logic [STORE_SHIFT_W-1:0] storeShift; // store left shift
  } mac_cmd_t;

  // status out
  typedef struct packed {
    logic accZero;       // accumulator zero
    logic accNeg;        // accumulator negative
    logic carry;         // carry from last add/sub
    logic overflow;      // signed overflow latched per op
    logic bitTest;       // tested bit
    logic normalized;    // no redundant sign bit left, or accumulator zero
  } mac_status_t;

endpackage

/* product_shifter.sv */
`timescale 1ns/1ps
module product_shifter
  import mac_pkg::*;
(
  // product and mode
  input  wire logic [ACC_W-1:0] product,
  input  wire pmode_t           pmode,
  // shifted product
  output logic      [ACC_W-1:0] shifted
);

  ////////////////////////////////////////////////////////////////////////////
  // four selectable product shifts
  always_comb begin
    case (pmode)
      PM_NONE: shifted = product;
      PM_L1:   shifted = product << PSHIFT_L1;
      PM_L4:   shifted = product << PSHIFT_L4;
      PM_R6:   shifted = ACC_W'($signed(product) >>> PSHIFT_R6);
      default: shifted = product;
    endcase
  end

endmodule

/* scaling_shifter.sv */
`timescale 1ns/1ps
module scaling_shifter
  import mac_pkg::*;
(
  // input word and control
  input  wire logic [DATA_W-1:0]  dataIn,
  input  wire logic [SHIFT_W-1:0] shiftCount,
  input  wire logic               signExtend,
  // shifted result
  output logic      [ACC_W-1:0]   dataOut
);

  logic [ACC_W-1:0] extended;    // widened input
  logic [SHIFT_W-1:0] amount;    // clamped shift

  ////////////////////////////////////////////////////////////////////////////
  // widen then shift, low bits zero
  always_comb begin
    amount = (shiftCount > SHIFT_W'(MAX_SHIFT)) ? SHIFT_W'(MAX_SHIFT) : shiftCount;
    if (signExtend) begin
      extended = {{(ACC_W-DATA_W){dataIn[DATA_W-1]}}, dataIn};
    end else begin
      extended = {{(ACC_W-DATA_W){1'b0}}, dataIn};
    end
    dataOut = extended << amount;
  end

endmodule
